// ### rtl/mpss_pkg.sv
// constants for the mode, privilege and stack select block
// assumes a single core clock and an active-low asynchronous reset
package mpss_pkg;
    localparam logic [31:0] MPSS_SP_VEC_ADDR    = 32'h0000_0000;
    localparam logic [31:0] MPSS_RESET_VEC_ADDR = 32'h0000_0004;
    localparam int          MPSS_CTRL_NPRIV_BIT = 0;
    localparam int          MPSS_CTRL_SPSEL_BIT = 1;
    localparam logic [1:0]  MPSS_CTRL_RESET     = 2'h0;
    localparam logic [31:0] MPSS_PUSH_STEP      = 32'h0000_0004;
    localparam logic [31:0] MPSS_WORD_RESET     = 32'h0000_0000;

    // start-up and run states
    typedef enum logic [3:0] {
        MPSS_FETCH_SP = 4'h1,
        MPSS_FETCH_PC = 4'h2,
        MPSS_THREAD   = 4'h4,
        MPSS_HANDLER  = 4'h8
    } mpss_state_t;
endpackage : mpss_pkg

// ### rtl/mpss_sp_bank.sv
// banked main and process stack pointers
// assumes control logic never asserts load and push for the same pointer
`timescale 1ns/1ps
module mpss_sp_bank
    import mpss_pkg::*;
(
    input wire logic   core_clk,
    input wire logic   rst_n,
    mpss_stack_if.bank sif
);
    logic [31:0] main_ff;
    logic [31:0] proc_ff;
    logic [31:0] nxt_main;
    logic [31:0] nxt_proc;

    always_comb
    begin
        nxt_main = main_ff;
        nxt_proc = proc_ff;
        // each pointer moves only on its own load or push
        if (sif.load_main)
            nxt_main = sif.load_val;
        else if (sif.push && !sif.sel_process)
            nxt_main = main_ff - MPSS_PUSH_STEP;
        if (sif.load_proc)
            nxt_proc = sif.load_val;
        else if (sif.push && sif.sel_process)
            nxt_proc = proc_ff - MPSS_PUSH_STEP;
    end

    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            main_ff <= MPSS_WORD_RESET;
            proc_ff <= MPSS_WORD_RESET;
        end
        else
        begin
            main_ff <= nxt_main;
            proc_ff <= nxt_proc;
        end
    end

    assign sif.main_sp   = main_ff;
    assign sif.proc_sp   = proc_ff;
    assign sif.active_sp = sif.sel_process ? proc_ff : main_ff;

    chk_main_indep: assert property (@(posedge core_clk) disable iff (!rst_n)
        (sif.push && sif.sel_process && !sif.load_main) |=> $stable(main_ff))
        else $error("main pointer moved on a process push");
endmodule : mpss_sp_bank

// ### rtl/mpss_stack_if.sv
// stack pointer bank interface
// assumes main and bank share core_clk
`timescale 1ns/1ps
interface mpss_stack_if;
    logic        sel_process;
    logic        load_main;
    logic        load_proc;
    logic        push;
    logic [31:0] load_val;
    logic [31:0] main_sp;
    logic [31:0] proc_sp;
    logic [31:0] active_sp;
    modport ctl  (output sel_process, load_main, load_proc, push, load_val,
                  input main_sp, proc_sp, active_sp);
    modport bank (input sel_process, load_main, load_proc, push, load_val,
                  output main_sp, proc_sp, active_sp);
endinterface : mpss_stack_if

// ### rtl/mpss_top.sv
// mode, privilege and stack pointer selection for the core
// assumes vector reads answer with rd_valid; core drives one-cycle event pulses
`timescale 1ns/1ps
module mpss_top
    import mpss_pkg::*;
(
    input  wire logic        core_clk,
    input  wire logic        rst_n,
    // vector fetch at start-up
    output logic             vec_rd_req,
    output logic [31:0]      vec_rd_addr,
    input  wire logic        vec_rd_valid,
    input  wire logic [31:0] vec_rd_data,
    // exception sequencing
    input  wire logic        exc_entry,
    input  wire logic        exc_return,
    // control register write and special register access
    input  wire logic        ctrl_wr,
    input  wire logic [1:0]  ctrl_wdata,
    input  wire logic        sp_wr_main,
    input  wire logic        sp_wr_proc,
    input  wire logic [31:0] sp_wdata,
    input  wire logic        push_req,
    // instruction and access checks
    input  wire logic        change_proc_state_instr,
    input  wire logic        sreg_access,
    input  wire logic        sreg_is_system,
    input  wire logic        sys_access,
    input  wire logic        supervisor_call_instr,
    // state outputs
    output logic             boot_done,
    output logic             handler_mode,
    output logic             privileged,
    output logic [1:0]       control_reg,
    output logic             use_process_sp,
    output logic [31:0]      main_stack_pointer,
    output logic [31:0]      process_stack_pointer,
    output logic [31:0]      active_sp,
    output logic [31:0]      push_addr,
    output logic             push_we,
    output logic [31:0]      pc_init,
    output logic             exec_state_bit,
    output logic             vector_fault,
    output logic             instr_denied,
    output logic             access_denied,
    output logic             supervisor_call_exc
);
    mpss_stack_if sif ();

    mpss_state_t state_ff;
    mpss_state_t nxt_state;
    logic [1:0]  ctrl_ff;
    logic [1:0]  nxt_ctrl;
    logic [31:0] pc_ff;
    logic [31:0] nxt_pc;
    logic        tbit_ff;
    logic        nxt_tbit;
    logic        vfault_ff;
    logic        nxt_vfault;
    logic        priv_now;
    logic        thread_now;

    ////////////////////////////////////////////////////////////////////////
    // mode sequencing

    assign thread_now = (state_ff == MPSS_THREAD);
    assign priv_now   = (state_ff == MPSS_HANDLER)
                      || !ctrl_ff[MPSS_CTRL_NPRIV_BIT];

    always_comb
    begin
        nxt_state  = state_ff;
        nxt_pc     = pc_ff;
        nxt_tbit   = tbit_ff;
        nxt_vfault = vfault_ff;
        unique case (state_ff)
            MPSS_FETCH_SP:
                if (vec_rd_valid)
                    nxt_state = MPSS_FETCH_PC;
            MPSS_FETCH_PC:
                if (vec_rd_valid)
                begin
                    nxt_pc     = {vec_rd_data[31:1], 1'b0};
                    nxt_tbit   = vec_rd_data[0];
                    nxt_vfault = !vec_rd_data[0];
                    nxt_state  = MPSS_THREAD;
                end
            MPSS_THREAD:
                if (exc_entry)
                    nxt_state = MPSS_HANDLER;
            MPSS_HANDLER:
                if (exc_return && !exc_entry)
                    nxt_state = MPSS_THREAD;
            default:
                nxt_state = MPSS_FETCH_SP;
        endcase
    end

    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            state_ff  <= MPSS_FETCH_SP;
            pc_ff     <= MPSS_WORD_RESET;
            tbit_ff   <= 1'b0;
            vfault_ff <= 1'b0;
        end
        else
        begin
            state_ff  <= nxt_state;
            pc_ff     <= nxt_pc;
            tbit_ff   <= nxt_tbit;
            vfault_ff <= nxt_vfault;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // control register

    always_comb
    begin
        nxt_ctrl = ctrl_ff;
        if (ctrl_wr && priv_now && (state_ff[2] || state_ff[3]))
            nxt_ctrl = ctrl_wdata;
    end

    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
            ctrl_ff <= MPSS_CTRL_RESET;
        else
            ctrl_ff <= nxt_ctrl;
    end

    ////////////////////////////////////////////////////////////////////////
    // stack pointer bank

    assign sif.sel_process = thread_now && ctrl_ff[MPSS_CTRL_SPSEL_BIT];
    assign sif.load_main   = ((state_ff == MPSS_FETCH_SP) && vec_rd_valid)
                           || (sp_wr_main && priv_now && !state_ff[0] && !state_ff[1]);
    assign sif.load_proc   = sp_wr_proc && (state_ff[2] || state_ff[3]);
    assign sif.load_val    = (state_ff == MPSS_FETCH_SP) ? vec_rd_data : sp_wdata;
    assign sif.push        = push_req && (state_ff[2] || state_ff[3]);

    mpss_sp_bank i_mpss_sp_bank (
        .core_clk (core_clk),
        .rst_n    (rst_n),
        .sif      (sif)
    );

    ////////////////////////////////////////////////////////////////////////
    // outputs and access checks

    assign vec_rd_req            = state_ff[0] || state_ff[1];
    assign vec_rd_addr           = state_ff[0] ? MPSS_SP_VEC_ADDR : MPSS_RESET_VEC_ADDR;
    assign boot_done             = state_ff[2] || state_ff[3];
    assign handler_mode          = (state_ff == MPSS_HANDLER);
    assign privileged            = priv_now;
    assign control_reg           = ctrl_ff;
    assign use_process_sp        = sif.sel_process;
    assign main_stack_pointer    = sif.main_sp;
    assign process_stack_pointer = sif.proc_sp;
    assign active_sp             = sif.active_sp;
    assign push_addr             = sif.active_sp - MPSS_PUSH_STEP;
    assign push_we               = sif.push;
    assign pc_init               = pc_ff;
    assign exec_state_bit        = tbit_ff;
    assign vector_fault          = vfault_ff;
    assign instr_denied          = !priv_now && (change_proc_state_instr
                                 || (sreg_access && sreg_is_system));
    assign access_denied         = !priv_now && sys_access;
    assign supervisor_call_exc   = supervisor_call_instr && boot_done;

    ////////////////////////////////////////////////////////////////////////
    // checks

    chk_reset_thread: assert property (@(posedge core_clk) disable iff (!rst_n)
        (state_ff == MPSS_FETCH_PC && vec_rd_valid) |=> (thread_now && !handler_mode))
        else $error("boot did not end in thread mode");

    chk_entry_handler: assert property (@(posedge core_clk) disable iff (!rst_n)
        (thread_now && exc_entry) |=> handler_mode)
        else $error("exception entry missed handler mode");

    chk_return_thread: assert property (@(posedge core_clk) disable iff (!rst_n)
        (handler_mode && exc_return && !exc_entry) |=> thread_now)
        else $error("exception return missed thread mode");

    chk_handler_priv: assert property (@(posedge core_clk) disable iff (!rst_n)
        handler_mode |-> privileged)
        else $error("handler mode not privileged");

    chk_thread_priv: assert property (@(posedge core_clk) disable iff (!rst_n)
        thread_now |-> (privileged == !control_reg[0]))
        else $error("thread privilege wrong");

    chk_state_deny: assert property (@(posedge core_clk) disable iff (!rst_n)
        (!privileged && change_proc_state_instr) |-> instr_denied)
        else $error("state change not refused");

    chk_sys_deny: assert property (@(posedge core_clk) disable iff (!rst_n)
        (access_denied |-> !privileged) and ((!privileged && sys_access) |-> access_denied))
        else $error("system access check wrong");

    chk_priv_gain: assert property (@(posedge core_clk) disable iff (!rst_n)
        (thread_now && !privileged && !exc_entry) |=> !privileged)
        else $error("privilege gained without an exception");

    chk_ctrl_guard: assert property (@(posedge core_clk) disable iff (!rst_n)
        (!privileged) |=> (control_reg == $past(control_reg)))
        else $error("control changed while unprivileged");

    chk_push_order: assert property (@(posedge core_clk) disable iff (!rst_n)
        (push_we && !sif.load_main && !sif.load_proc) |=>
            (($past(use_process_sp) ? process_stack_pointer : main_stack_pointer)
            == $past(push_addr)))
        else $error("push did not predecrement");

    chk_handler_main: assert property (@(posedge core_clk) disable iff (!rst_n)
        handler_mode |-> (active_sp == main_stack_pointer && !use_process_sp))
        else $error("handler not on main stack");

    chk_thread_sel: assert property (@(posedge core_clk) disable iff (!rst_n)
        thread_now |-> (use_process_sp == control_reg[1]))
        else $error("thread stack select wrong");

    chk_main_load: assert property (@(posedge core_clk) disable iff (!rst_n)
        (state_ff == MPSS_FETCH_SP && vec_rd_valid) |=>
            (main_stack_pointer == $past(vec_rd_data)))
        else $error("main pointer not loaded at boot");

    chk_tbit_load: assert property (@(posedge core_clk) disable iff (!rst_n)
        (state_ff == MPSS_FETCH_PC && vec_rd_valid) |=>
            (exec_state_bit == $past(vec_rd_data[0])))
        else $error("state bit not loaded");

    chk_sreg_deny: assert property (@(posedge core_clk) disable iff (!rst_n)
        (!privileged && sreg_access && sreg_is_system) |-> instr_denied)
        else $error("special register access not refused");

    chk_priv_allow: assert property (@(posedge core_clk) disable iff (!rst_n)
        privileged |-> (!instr_denied && !access_denied))
        else $error("privileged code refused");

    chk_super_call: assert property (@(posedge core_clk) disable iff (!rst_n)
        (boot_done && supervisor_call_instr) |-> supervisor_call_exc)
        else $error("supervisor call not raised");

    chk_call_boot: assert property (@(posedge core_clk) disable iff (!rst_n)
        !boot_done |-> !supervisor_call_exc)
        else $error("supervisor call raised before boot");

    chk_ctrl_write: assert property (@(posedge core_clk) disable iff (!rst_n)
        (ctrl_wr && privileged && boot_done) |=> (control_reg == $past(ctrl_wdata)))
        else $error("privileged control write lost");

    chk_proc_indep: assert property (@(posedge core_clk) disable iff (!rst_n)
        (push_we && !use_process_sp && !sif.load_proc) |=> $stable(process_stack_pointer))
        else $error("process pointer moved on a main push");

    chk_main_write: assert property (@(posedge core_clk) disable iff (!rst_n)
        (sp_wr_main && privileged && boot_done) |=> (main_stack_pointer == $past(sp_wdata)))
        else $error("main pointer write lost");

    chk_proc_write: assert property (@(posedge core_clk) disable iff (!rst_n)
        (sp_wr_proc && boot_done) |=> (process_stack_pointer == $past(sp_wdata)))
        else $error("process pointer write lost");

    chk_proc_active: assert property (@(posedge core_clk) disable iff (!rst_n)
        use_process_sp |-> (thread_now && active_sp == process_stack_pointer))
        else $error("process stack used outside thread mode");

    chk_sp_addr: assert property (@(posedge core_clk) disable iff (!rst_n)
        (state_ff == MPSS_FETCH_SP) |-> (vec_rd_req && vec_rd_addr == MPSS_SP_VEC_ADDR))
        else $error("stack vector address wrong");

    chk_pc_addr: assert property (@(posedge core_clk) disable iff (!rst_n)
        (state_ff == MPSS_FETCH_PC) |-> (vec_rd_req && vec_rd_addr == MPSS_RESET_VEC_ADDR))
        else $error("reset vector address wrong");

    chk_pc_load: assert property (@(posedge core_clk) disable iff (!rst_n)
        (state_ff == MPSS_FETCH_PC && vec_rd_valid) |=>
            (pc_init == {$past(vec_rd_data[31:1]), 1'b0}))
        else $error("start address not loaded");

    chk_vec_fault: assert property (@(posedge core_clk) disable iff (!rst_n)
        (state_ff == MPSS_FETCH_PC && vec_rd_valid) |=>
            (vector_fault == !$past(vec_rd_data[0])))
        else $error("vector fault flag wrong");

    chk_entry_wins: assert property (@(posedge core_clk) disable iff (!rst_n)
        (handler_mode && exc_entry) |=> handler_mode)
        else $error("return taken over a new entry");

    chk_boot_mode: assert property (@(posedge core_clk) disable iff (!rst_n)
        !boot_done |=> !handler_mode)
        else $error("handler mode entered during boot");

    ////////////////////////////////////////////////////////////////////////
    // scenario coverage

    cov_boot: cover property (@(posedge core_clk) disable iff (!rst_n)
        (state_ff == MPSS_FETCH_PC && vec_rd_valid) ##1 thread_now);

    cov_exc_round: cover property (@(posedge core_clk) disable iff (!rst_n)
        (thread_now && exc_entry) ##1 handler_mode [*2] ##1 thread_now);

    cov_unpriv_deny: cover property (@(posedge core_clk) disable iff (!rst_n)
        access_denied);

    cov_process_push: cover property (@(posedge core_clk) disable iff (!rst_n)
        push_we && use_process_sp);

    cov_ctrl_refused: cover property (@(posedge core_clk) disable iff (!rst_n)
        !privileged && ctrl_wr);
endmodule : mpss_top

// ### verification/mpss_top_tb.sv
// self-checking bench for the mode, privilege and stack select block
// assumes the design checks its own assertions; the bench drives every input
`timescale 1ns/1ps
module mpss_top_tb;
    import mpss_pkg::*;
    logic        core_clk, rst_n, vec_rd_req, vec_rd_valid, exc_entry, exc_return;
    logic        ctrl_wr, sp_wr_main, sp_wr_proc, push_req, change_proc_state_instr;
    logic        sreg_access, sreg_is_system, sys_access, supervisor_call_instr;
    logic        boot_done, handler_mode;
    logic        privileged, use_process_sp, push_we, exec_state_bit, vector_fault;
    logic        instr_denied, access_denied, supervisor_call_exc;
    logic [1:0]  ctrl_wdata, control_reg;
    logic [31:0] vec_rd_addr, vec_rd_data, sp_wdata, main_stack_pointer;
    logic [31:0] process_stack_pointer, active_sp, push_addr, pc_init, exp_main, exp_proc;
    int          num_errors, num_checks, cycles;
    ////////////////////////////////////////////////////////////////////////////
    mpss_top i_mpss_top (.core_clk(core_clk), .rst_n(rst_n), .vec_rd_req(vec_rd_req),
        .vec_rd_addr(vec_rd_addr), .vec_rd_valid(vec_rd_valid), .vec_rd_data(vec_rd_data),
        .exc_entry(exc_entry), .exc_return(exc_return), .ctrl_wr(ctrl_wr),
        .ctrl_wdata(ctrl_wdata), .sp_wr_main(sp_wr_main), .sp_wr_proc(sp_wr_proc),
        .sp_wdata(sp_wdata), .push_req(push_req),
        .change_proc_state_instr(change_proc_state_instr),
        .sreg_access(sreg_access), .sreg_is_system(sreg_is_system),
        .sys_access(sys_access), .supervisor_call_instr(supervisor_call_instr),
        .boot_done(boot_done),
        .handler_mode(handler_mode), .privileged(privileged), .control_reg(control_reg),
        .use_process_sp(use_process_sp), .main_stack_pointer(main_stack_pointer),
        .process_stack_pointer(process_stack_pointer), .active_sp(active_sp),
        .push_addr(push_addr), .push_we(push_we), .pc_init(pc_init),
        .exec_state_bit(exec_state_bit), .vector_fault(vector_fault),
        .instr_denied(instr_denied), .access_denied(access_denied),
        .supervisor_call_exc(supervisor_call_exc));
    ////////////////////////////////////////////////////////////////////////////
    initial
    begin
        core_clk = 1'b0;
        forever #2 core_clk = ~core_clk;
    end
    always @(posedge core_clk)
    begin
        cycles++;
        if (cycles == 2000)
        begin
            num_errors++;
            end_of_test();
        end
    end
    ////////////////////////////////////////////////////////////////////////////
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : end_of_test
    task automatic chk1(input logic got, input logic exp);
        num_checks++;
        if (got !== exp)
        begin
            num_errors++;
            $display("unexpected at %0t: got %h exp %h", $time, got, exp);
        end
    endtask : chk1
    task automatic chk32(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp)
        begin
            num_errors++;
            $display("unexpected at %0t: got %h exp %h", $time, got, exp);
        end
    endtask : chk32
    task automatic tick();
        @(posedge core_clk);
    endtask : tick
    ////////////////////////////////////////////////////////////////////////////
    // reset, then answer both vector reads back to back
    task automatic t_boot(input logic [31:0] sp, input logic [31:0] pc);
        tick();
        rst_n <= 1'b0;
        repeat (2) tick();
        rst_n <= 1'b1;
        tick();
        vec_rd_valid <= 1'b1;
        vec_rd_data  <= sp;
        #1 chk32(vec_rd_addr, MPSS_SP_VEC_ADDR);
        chk1(vec_rd_req, 1'b1);
        tick();
        vec_rd_data <= pc;
        #1 chk32(main_stack_pointer, sp);
        chk32(vec_rd_addr, MPSS_RESET_VEC_ADDR);
        tick();
        vec_rd_valid <= 1'b0;
        vec_rd_data  <= ~pc;
        #1 chk1(boot_done, 1'b1);
        chk32(pc_init, {pc[31:1], 1'b0});
        chk1(exec_state_bit, pc[0]);
        chk1(vector_fault, ~pc[0]);
        chk1(handler_mode, 1'b0);
        chk1(privileged, 1'b1);
        chk32({30'h0, control_reg}, {30'h0, MPSS_CTRL_RESET});
        chk1(use_process_sp, 1'b0);
        exp_main = sp;
        $display("test boot done");
    endtask : t_boot
    // one push: address is pointer minus a word, pointer follows next cycle
    task automatic t_push(input logic [31:0] sp, input logic to_proc);
        tick();
        push_req <= 1'b1;
        #1 chk1(push_we, 1'b1);
        chk32(push_addr, sp - MPSS_PUSH_STEP);
        tick();
        push_req <= 1'b0;
        #1 chk32(active_sp, sp - MPSS_PUSH_STEP);
        if (to_proc)
            exp_proc = sp - MPSS_PUSH_STEP;
        else
            exp_main = sp - MPSS_PUSH_STEP;
        chk32(main_stack_pointer, exp_main);
        chk32(process_stack_pointer, exp_proc);
    endtask : t_push
    // process stack selected in thread mode, pushes touch only that pointer
    task automatic t_stack_select();
        tick();
        sp_wr_proc <= 1'b1;
        sp_wdata   <= 32'h2000_0800;
        tick();
        sp_wr_proc <= 1'b0;
        ctrl_wr    <= 1'b1;
        ctrl_wdata <= 2'h2;
        exp_proc = 32'h2000_0800;
        tick();
        ctrl_wr <= 1'b0;
        #1 chk1(use_process_sp, 1'b1);
        chk32(active_sp, exp_proc);
        t_push(exp_proc, 1'b1);
        t_push(exp_proc, 1'b1);
        $display("test stack select done");
    endtask : t_stack_select
    // drop to unprivileged, try refused actions, then recover via an exception
    task automatic t_unpriv();
        tick();
        ctrl_wr    <= 1'b1;
        ctrl_wdata <= 2'h3;
        tick();
        ctrl_wr                 <= 1'b0;
        change_proc_state_instr <= 1'b1;
        sys_access              <= 1'b1;
        supervisor_call_instr   <= 1'b1;
        sp_wr_main              <= 1'b1;
        sp_wdata                <= 32'h0000_1230;
        #1 chk1(privileged, 1'b0);
        chk1(instr_denied, 1'b1);
        chk1(access_denied, 1'b1);
        chk1(supervisor_call_exc, 1'b1);
        tick();
        change_proc_state_instr <= 1'b0;
        sys_access              <= 1'b0;
        supervisor_call_instr   <= 1'b0;
        sp_wr_main              <= 1'b0;
        sreg_access             <= 1'b1;
        sreg_is_system          <= 1'b1;
        ctrl_wr                 <= 1'b1;
        ctrl_wdata              <= 2'h0;
        #1 chk1(instr_denied, 1'b1);
        chk1(access_denied, 1'b0);
        chk1(supervisor_call_exc, 1'b0);
        tick();
        ctrl_wr    <= 1'b0;
        exc_entry  <= 1'b1;
        sys_access <= 1'b1;
        #1 chk32({30'h0, control_reg}, 32'h0000_0003);
        chk32(main_stack_pointer, exp_main);
        chk1(access_denied, 1'b1);
        tick();
        exc_entry <= 1'b0;
        #1 chk1(handler_mode, 1'b1);
        chk1(privileged, 1'b1);
        chk1(instr_denied | access_denied, 1'b0);
        chk1(use_process_sp, 1'b0);
        chk32(active_sp, exp_main);
        t_push(exp_main, 1'b0);
        tick();
        ctrl_wr    <= 1'b1;
        ctrl_wdata <= 2'h2;
        tick();
        ctrl_wr        <= 1'b0;
        exc_return     <= 1'b1;
        sys_access     <= 1'b0;
        sreg_access    <= 1'b0;
        sreg_is_system <= 1'b0;
        tick();
        exc_return <= 1'b0;
        #1 chk1(handler_mode, 1'b0);
        chk1(privileged, 1'b1);
        chk32(active_sp, exp_proc);
        $display("test unprivileged done");
    endtask : t_unpriv
    ////////////////////////////////////////////////////////////////////////////
    initial
    begin
        {rst_n, vec_rd_valid, exc_entry, exc_return, ctrl_wr, sp_wr_main} = 6'h00;
        {sp_wr_proc, push_req, change_proc_state_instr, sreg_access, sreg_is_system} = 5'h00;
        {sys_access, supervisor_call_instr, ctrl_wdata} = 4'h0;
        vec_rd_data = 32'h0000_0000;
        sp_wdata    = 32'h0000_0000;
        exp_proc    = MPSS_WORD_RESET;
        t_boot(32'h2000_1000, 32'h0800_0101);
        t_push(exp_main, 1'b0);
        t_stack_select();
        t_unpriv();
        exp_proc = MPSS_WORD_RESET;
        t_boot(32'h2000_2000, 32'h0800_0200);
        end_of_test();
    end
endmodule : mpss_top_tb
